// >>> rtl/mds_pkg.sv
// package: constants and types for the memory data switch and its cycle timing
package mds_pkg;

   // ----------------------------------------------------------------
   // widths and byte lanes
   // ----------------------------------------------------------------
   localparam int DATA_W   = 64;              // full data path
   localparam int HALF_W   = 32;              // one inner or outer word
   localparam int BYTE_W   = 8;               // one holding slice
   localparam int N_SLICE  = 8;               // eight byte slices
   // slice membership, bit i = slice i+1; outer = 1,6,7,8; inner = 2..5
   localparam logic [7:0] OUTER_SLICES = 8'hE1;
   localparam logic [7:0] INNER_SLICES = 8'h1E;

   // ----------------------------------------------------------------
   // timing figures in nanoseconds
   // ----------------------------------------------------------------
   localparam int CLK_NS        = 50;         // 20 MHz clock period
   localparam int STAGE_NS      = 50;         // one tapped delay stage
   localparam int TAP_NS        = 5;          // tap resolution
   localparam int N_STAGES      = 12;         // chained delay stages
   localparam int VAR_MAX_NS    = 50;         // adjustable delay ceiling
   localparam int WORD_LATCH_NS = 40;         // word enable capture
   localparam int STROBE_NS     = 55;         // holding latch strobe
   localparam int STROBE_W_NS   = 8;          // strobe pulse width
   localparam int RDSEL_NS      = 130;        // read select latch
   localparam int XFER_SET_NS   = 165;        // transfer enable set
   localparam int XFER_CLR_NS   = 265;        // transfer enable reset
   localparam int OUT_SET_NS    = 270;        // output enable set
   localparam int OUT_CLR_NS    = 370;        // output enable reset
   localparam int MEM_VALID_NS  = 225;        // memory read data valid
   localparam int ELEM_VALID_NS = 235;        // element read data valid
   localparam int WR_HOLD_NS    = 250;        // memory write data valid

   // ----------------------------------------------------------------
   // derived cycle counts (least times round up, at least one)
   // ----------------------------------------------------------------
   function automatic int ns_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_up

   localparam int CNT_W = 4;                  // cycle counter width
   localparam logic [3:0] WORD_LATCH_CYC = 4'(ns_up(WORD_LATCH_NS));
   localparam logic [3:0] STROBE_CYC     = 4'(ns_up(STROBE_NS));
   localparam logic [3:0] RDSEL_CYC      = 4'(ns_up(RDSEL_NS));
   localparam logic [3:0] XFER_SET_CYC   = 4'(ns_up(XFER_SET_NS));
   localparam logic [3:0] XFER_CLR_CYC   = 4'(ns_up(XFER_CLR_NS));
   localparam logic [3:0] OUT_SET_CYC    = 4'(ns_up(OUT_SET_NS));
   localparam logic [3:0] OUT_CLR_CYC    = 4'(ns_up(OUT_CLR_NS));
   localparam logic [3:0] MEM_VALID_CYC  = 4'(ns_up(MEM_VALID_NS));
   localparam logic [3:0] ELEM_VALID_CYC = 4'(ns_up(ELEM_VALID_NS));
   localparam logic [3:0] WR_END_CYC     = 4'(ns_up(STROBE_NS + WR_HOLD_NS));
   localparam logic [3:0] CYCLE_END_CYC  = 4'(ns_up(N_STAGES * STAGE_NS));
   localparam logic [3:0] CNT_ONE        = 4'h1;
   localparam logic [3:0] CNT_ZERO       = 4'h0;

   // ----------------------------------------------------------------
   // cycle sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MDS_IDLE,
      MDS_RUN
   } mds_state_t;

endpackage : mds_pkg

// >>> rtl/mds_cycle_timer.sv
// cycle timer: counts clock periods from the cycle initiate
`timescale 1ns/1ns
module mds_cycle_timer (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // control
   input  wire logic                    cycleStart,
   // position in the cycle
   output logic [mds_pkg::CNT_W-1:0]    cycleCount,
   output logic                         cycleBusy
);

   mds_pkg::mds_state_t state;        // sequencer state
   mds_pkg::mds_state_t next_state;   // next sequencer state

   // ----------------------------------------------------------------
   // sequencer: idle until initiate, run to end of chain
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         mds_pkg::MDS_IDLE: begin
            if (cycleStart) begin
               next_state = mds_pkg::MDS_RUN;
            end
         end
         mds_pkg::MDS_RUN: begin
            // a fresh initiate restarts; end only at chain tail
            if (!cycleStart && cycleCount == mds_pkg::CYCLE_END_CYC) begin
               next_state = mds_pkg::MDS_IDLE;
            end
         end
         default: next_state = mds_pkg::MDS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= mds_pkg::MDS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // counter: count 1 is the cycle after the initiate
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cycleCount <= mds_pkg::CNT_ZERO;
      end else if (cycleStart) begin
         cycleCount <= mds_pkg::CNT_ONE;
      end else if (state == mds_pkg::MDS_RUN && cycleCount != mds_pkg::CYCLE_END_CYC) begin
         cycleCount <= cycleCount + mds_pkg::CNT_ONE;
      end else if (next_state == mds_pkg::MDS_IDLE) begin
         cycleCount <= mds_pkg::CNT_ZERO;
      end
   end

   assign cycleBusy = (state == mds_pkg::MDS_RUN);

endmodule : mds_cycle_timer

// >>> rtl/mds_byte_slice.sv
// byte slice: one holding latch with source steering
`timescale 1ns/1ns
module mds_byte_slice (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // steering
   input  wire logic                       strobe,
   input  wire logic                       wordEnable,
   input  wire logic                       elementSel,
   input  wire logic                       ioSel,
   // data
   input  wire logic [mds_pkg::BYTE_W-1:0] elementByte,
   input  wire logic [mds_pkg::BYTE_W-1:0] ioByte,
   output logic      [mds_pkg::BYTE_W-1:0] heldByte
);

   // ----------------------------------------------------------------
   // holding latch; element path needs its word enable, io does not
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         heldByte <= '0;
      end else if (strobe) begin
         if (elementSel && wordEnable) begin
            heldByte <= elementByte;
         end else if (ioSel) begin
            heldByte <= ioByte;
         end
      end
   end

endmodule : mds_byte_slice

// >>> rtl/mds_switch.sv
// top: 64-bit memory data switch with cycle timing chain
`timescale 1ns/1ns
module mds_switch (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // cycle control from the processing element
   input  wire logic                       cycle_initiate,
   input  wire logic                       readWrite,
   input  wire logic                       transferCycle,
   input  wire logic                       outerWordRequest,
   input  wire logic                       innerWordRequest,
   // source and destination decode
   input  wire logic                       element_source_select,
   input  wire logic                       io_sub_write_select,
   input  wire logic                       buffer_read_select,
   input  wire logic                       io_sub_read_select,
   // data inputs
   input  wire logic [mds_pkg::DATA_W-1:0] element_write_data_in,
   input  wire logic [mds_pkg::DATA_W-1:0] io_sub_write_data_in,
   input  wire logic [mds_pkg::DATA_W-1:0] memory_read_data_in,
   // data outputs
   output logic      [mds_pkg::DATA_W-1:0] memory_write_data_out,
   output logic                            memoryWriteValid,
   output logic      [mds_pkg::DATA_W-1:0] element_read_data_out,
   output logic                            elementReadValid,
   output logic      [mds_pkg::DATA_W-1:0] buffer_io_out_data,
   // timing and status
   output logic                            holding_latch_strobe,
   output logic                            transfer_enable_gate,
   output logic                            output_enable_gate,
   output logic                            outer_word_enable_latched,
   output logic                            inner_word_enable_latched,
   output logic                            buffer_read_select_latched,
   output logic                            ioReadSelectLatched,
   output logic                            cycleBusy
);

   // ----------------------------------------------------------------
   // synchronisers for pin inputs
   // ----------------------------------------------------------------
   localparam int N_CTL = 9;                          // synchronised control lines
   logic [N_CTL-1:0] ctlMeta;                         // first stage, read only by ctlSync
   logic [N_CTL-1:0] ctlSync;                         // second stage
   logic [mds_pkg::DATA_W-1:0] elemMeta;              // element data stage one
   logic [mds_pkg::DATA_W-1:0] elemSync;              // element data stage two
   logic [mds_pkg::DATA_W-1:0] ioMeta;                // io data stage one
   logic [mds_pkg::DATA_W-1:0] ioSync;                // io data stage two
   logic [mds_pkg::DATA_W-1:0] memMeta;               // memory data stage one
   logic [mds_pkg::DATA_W-1:0] memSync;               // memory data stage two

   // data buses share the same two-stage delay as controls, so the
   // relative cycle timing of pins is kept through the crossing
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctlMeta  <= '0;
         ctlSync  <= '0;
         elemMeta <= '0;
         elemSync <= '0;
         ioMeta   <= '0;
         ioSync   <= '0;
         memMeta  <= '0;
         memSync  <= '0;
      end else begin
         ctlMeta  <= {cycle_initiate, readWrite, transferCycle, outerWordRequest, innerWordRequest,
                      element_source_select, io_sub_write_select, buffer_read_select, io_sub_read_select};
         ctlSync  <= ctlMeta;
         elemMeta <= element_write_data_in;
         elemSync <= elemMeta;
         ioMeta   <= io_sub_write_data_in;
         ioSync   <= ioMeta;
         memMeta  <= memory_read_data_in;
         memSync  <= memMeta;
      end
   end

   // named views of the synchronised controls
   logic initiateS;       // cycle initiate
   logic writeCycleS;     // high requests write
   logic transferS;       // transfer cycle
   logic outerReqS;       // outer word request
   logic innerReqS;       // inner word request
   logic elemSelS;        // element is the source
   logic ioWrSelS;        // io is the write source
   logic bufRdSelS;       // buffer is read destination
   logic ioRdSelS;        // io is read destination
   assign {initiateS, writeCycleS, transferS, outerReqS, innerReqS,
           elemSelS, ioWrSelS, bufRdSelS, ioRdSelS} = ctlSync;

   // ----------------------------------------------------------------
   // cycle start and timing chain
   // ----------------------------------------------------------------
   logic                       initiateDly;   // previous initiate level
   logic                       cycleStart;    // one pulse per initiate
   logic [mds_pkg::CNT_W-1:0]  cycleCount;    // position in the cycle

   // the initiate is one clock wide, but an edge keeps a held line
   // from restarting the cycle on every clock
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         initiateDly <= 1'b0;
      end else begin
         initiateDly <= initiateS;
      end
   end
   assign cycleStart = initiateS && !initiateDly;

   // one shared counter stands in for the chained delay stages;
   // each tap below is a compare against its count
   mds_cycle_timer u_timer (
      .clock      (clock),
      .rst_n      (rst_n),
      .cycleStart (cycleStart),
      .cycleCount (cycleCount),
      .cycleBusy  (cycleBusy)
   );

   // compare helper, each delay-line tap becomes one of these
   function automatic logic at_tap(input logic [mds_pkg::CNT_W-1:0] cnt,
                                   input logic [mds_pkg::CNT_W-1:0] tap);
      return cnt == tap;
   endfunction : at_tap

   logic tapWordLatch;   // word request capture point
   logic tapStrobe;      // holding strobe point
   logic tapRdSel;       // read select capture point
   logic tapXferSet;     // transfer enable set
   logic tapXferClr;     // transfer enable reset
   logic tapOutSet;      // output enable set
   logic tapOutClr;      // output enable reset
   logic tapMemValid;    // memory data valid point
   logic tapElemValid;   // element data valid point
   logic tapWrEnd;       // end of write data window

   // taps that share a count fire in the same clock; which one
   // acts first is settled by the process that reads them
   assign tapWordLatch = at_tap(cycleCount, mds_pkg::WORD_LATCH_CYC);
   assign tapStrobe    = at_tap(cycleCount, mds_pkg::STROBE_CYC);
   assign tapRdSel     = at_tap(cycleCount, mds_pkg::RDSEL_CYC);
   assign tapXferSet   = at_tap(cycleCount, mds_pkg::XFER_SET_CYC);
   assign tapXferClr   = at_tap(cycleCount, mds_pkg::XFER_CLR_CYC);
   assign tapOutSet    = at_tap(cycleCount, mds_pkg::OUT_SET_CYC);
   assign tapOutClr    = at_tap(cycleCount, mds_pkg::OUT_CLR_CYC);
   assign tapMemValid  = at_tap(cycleCount, mds_pkg::MEM_VALID_CYC);
   assign tapElemValid = at_tap(cycleCount, mds_pkg::ELEM_VALID_CYC);
   assign tapWrEnd     = at_tap(cycleCount, mds_pkg::WR_END_CYC);

   // ----------------------------------------------------------------
   // word enable latches
   // ----------------------------------------------------------------
   // captured once per cycle; io bytes are written without them, element bytes need them
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         outer_word_enable_latched <= 1'b0;
         inner_word_enable_latched <= 1'b0;
      end else if (tapWordLatch) begin
         outer_word_enable_latched <= outerReqS;
         inner_word_enable_latched <= innerReqS;
      end
   end

   // ----------------------------------------------------------------
   // read select latches
   // ----------------------------------------------------------------
   // set at 130 ns, held until output enable period has passed
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         buffer_read_select_latched <= 1'b0;
         ioReadSelectLatched        <= 1'b0;
      end else if (tapRdSel) begin
         buffer_read_select_latched <= bufRdSelS && !writeCycleS;
         ioReadSelectLatched        <= ioRdSelS && !writeCycleS;
      end else if (tapOutClr) begin
         buffer_read_select_latched <= 1'b0;
         ioReadSelectLatched        <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // holding latch strobe
   // ----------------------------------------------------------------
   // 8 ns cannot be made at 20 MHz; one clock period is the shortest
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         holding_latch_strobe <= 1'b0;
      end else begin
         holding_latch_strobe <= tapStrobe && (writeCycleS || transferS);
      end
   end

   // ----------------------------------------------------------------
   // byte slices of the holding register
   // ----------------------------------------------------------------
   logic [mds_pkg::DATA_W-1:0] elemLevels;   // internal sense of element data
   logic [mds_pkg::DATA_W-1:0] heldWord;     // holding register contents
   logic [mds_pkg::N_SLICE-1:0] sliceEnable; // per slice word enable

   // element pins are positive logic; the inside works negative
   assign elemLevels = ~elemSync;

   always_comb begin
      for (int s = 0; s < mds_pkg::N_SLICE; s++) begin
         sliceEnable[s] = (mds_pkg::OUTER_SLICES[s] && outer_word_enable_latched) ||
                          (mds_pkg::INNER_SLICES[s] && inner_word_enable_latched);
      end
   end

   for (genvar g = 0; g < mds_pkg::N_SLICE; g++) begin : g_slice
      mds_byte_slice u_slice (
         .clock       (clock),
         .rst_n       (rst_n),
         .strobe      (holding_latch_strobe),
         .wordEnable  (sliceEnable[g]),
         .elementSel  (elemSelS),
         .ioSel       (ioWrSelS && !transferS),
         .elementByte (elemLevels[g*mds_pkg::BYTE_W +: mds_pkg::BYTE_W]),
         .ioByte      (ioSync[g*mds_pkg::BYTE_W +: mds_pkg::BYTE_W]),
         .heldByte    (heldWord[g*mds_pkg::BYTE_W +: mds_pkg::BYTE_W])
      );
   end

   // ----------------------------------------------------------------
   // write data to element memory
   // ----------------------------------------------------------------
   // driven from the strobe until the 250 ns window has run out
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         memoryWriteValid <= 1'b0;
      end else if (tapWrEnd) begin
         memoryWriteValid <= 1'b0;
      end else if (holding_latch_strobe && writeCycleS && !transferS) begin
         memoryWriteValid <= 1'b1;
      end
   end
   // the holding register drives the memory bus directly; the valid
   // flag frames the window in which memory may take it
   assign memory_write_data_out = heldWord;

   // ----------------------------------------------------------------
   // transfer and output enable flip-flops
   // ----------------------------------------------------------------
   // each gate is a set/reset pair on two taps; set is tested first,
   // though the two taps of one gate never share a count
   // transfer gate opens only in transfer cycles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         transfer_enable_gate <= 1'b0;
      end else if (tapXferSet && transferS) begin
         transfer_enable_gate <= 1'b1;
      end else if (tapXferClr) begin
         transfer_enable_gate <= 1'b0;
      end
   end

   // output gate opens only in read cycles; its set tap shares a
   // count with the transfer reset, which is harmless as the two
   // gates never run in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         output_enable_gate <= 1'b0;
      end else if (tapOutSet && !writeCycleS && !transferS) begin
         output_enable_gate <= 1'b1;
      end else if (tapOutClr) begin
         output_enable_gate <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data capture and element read path
   // ----------------------------------------------------------------
   // read word feeds the buffer side through the output gate
   logic [mds_pkg::DATA_W-1:0] readWord;   // memory word held for the cycle

   // sampled once it is valid, held into the next cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         readWord <= '0;
      end else if (tapMemValid && !writeCycleS && !transferS) begin
         readWord <= memSync;
      end
   end

   // element copy comes straight from the synchronised bus: its tap
   // falls on the same count as the readWord capture, and readWord
   // would still hold the word of the cycle before
   // the valid flag holds over following reads and drops when a
   // write starts, so a write cycle never shows a stale read as valid
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         element_read_data_out <= '0;
         elementReadValid      <= 1'b0;
      end else if (tapElemValid && !writeCycleS && !transferS) begin
         element_read_data_out <= memSync;
         elementReadValid      <= 1'b1;
      end else if (cycleStart && writeCycleS) begin
         elementReadValid      <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read/transfer selector toward buffer and io
   // ----------------------------------------------------------------
   // transfer data is tested first; the gates never overlap, so the
   // priority only matters if the taps are ever moved together
   // the bus keeps its last word when neither gate is open
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         buffer_io_out_data <= '0;
      end else if (transfer_enable_gate) begin
         buffer_io_out_data <= heldWord;
      end else if (output_enable_gate) begin
         buffer_io_out_data <= readWord;
      end
   end

endmodule : mds_switch

// >>> testbench/mds_mem_model.sv
// partner: element memory, read word valid only in its window
`timescale 1ns/1ns
module mds_mem_model (
   // clock and cycle pin
   input  wire logic        clock,
   input  wire logic        cycle_initiate,
   // stored word and read bus
   input  wire logic [63:0] word,
   output logic      [63:0] memory_read_data_in
);
   int n = 99; // clocks since initiate
   // outside the window the bus shows the inverse, so stale data cannot match
   always @(posedge clock) begin
      n <= cycle_initiate ? 0 : n + 1;
      memory_read_data_in <= (n > 2 && n < 16) ? word : ~word;
   end
endmodule : mds_mem_model

// >>> testbench/mds_switch_properties.sv
// checker: port timing of the memory data switch
`timescale 1ns/1ns
module mds_switch_properties (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // watched ports
   input wire logic        cycle_initiate,
   input wire logic        readWrite,
   input wire logic        holding_latch_strobe,
   input wire logic        transfer_enable_gate,
   input wire logic        output_enable_gate,
   input wire logic        memoryWriteValid,
   input wire logic [63:0] memory_write_data_out,
   input wire logic        cycleBusy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // cycle steps, counted from the initiate
   // ----------------------------------------------------------------
   sequence writeStart; $rose(cycle_initiate) && readWrite; endsequence
   sequence readStart; $rose(cycle_initiate) && !readWrite; endsequence
   sequence twoClocks(g); g [*2] ##1 !g; endsequence // set and reset taps 100 ns apart
   chk_strobe_pulse: assert property (holding_latch_strobe |=> !holding_latch_strobe)
      else $error("strobe too long");
   chk_strobe_place: assert property (writeStart |-> ##[3:6] holding_latch_strobe)
      else $error("strobe missing");
   chk_xfer_gate_len: assert property ($rose(transfer_enable_gate) |-> twoClocks(transfer_enable_gate))
      else $error("transfer gate width");
   chk_out_gate_len: assert property ($rose(output_enable_gate) |-> twoClocks(output_enable_gate))
      else $error("output gate width");
   chk_out_gate_place: assert property (readStart |-> ##[8:10] output_enable_gate)
      else $error("output gate missing");
   chk_gates_apart: assert property (!(transfer_enable_gate && output_enable_gate))
      else $error("gates overlap");
   chk_write_hold: assert property (memoryWriteValid && $past(memoryWriteValid) |-> $stable(memory_write_data_out))
      else $error("write data moved");
   chk_busy_len: assert property ($rose(cycleBusy) |-> cycleBusy [*8])
      else $error("cycle too short");
endmodule : mds_switch_properties
bind mds_switch mds_switch_properties chk_u (.*);

// >>> testbench/mds_switch_tb.sv
// testbench: switch against a bench model of holding latches and read path
`timescale 1ns/1ns
module mds_switch_tb;
   // ----------------------------------------------------------------
   // signals carry the port names so instances connect by name
   // ----------------------------------------------------------------
   logic clock = 0, rst_n = 0, cycle_initiate = 0, readWrite = 0, transferCycle = 0;
   logic outerWordRequest = 0, innerWordRequest = 0, element_source_select = 0, io_sub_write_select = 0;
   logic buffer_read_select = 0, io_sub_read_select = 0, memoryWriteValid, elementReadValid, cycleBusy;
   logic holding_latch_strobe, transfer_enable_gate, output_enable_gate, ioReadSelectLatched;
   logic outer_word_enable_latched, inner_word_enable_latched, buffer_read_select_latched;
   logic [63:0] element_write_data_in = 0, io_sub_write_data_in = 0, memory_read_data_in;
   logic [63:0] memory_write_data_out, element_read_data_out, buffer_io_out_data, word = 0;
   logic [63:0] held = 0, rdExp = 0; // model of holding latches, last word read
   int n_fail = 0, samples_checked = 0, seed = 32'hac94, ticks = 0, r;
   mds_switch dut_u (.*);
   mds_mem_model mem_u (.*);
   always #25 clock = ~clock;
   // hang guard: the run needs about 200 clocks
   always @(posedge clock) if (++ticks == 1000) begin
      n_fail++;
      wrap_up();
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   // one cycle: one-clock initiate, controls held, source data held seven clocks
   task automatic run(input logic rw, tc, ow, iw, es, ios, brs, irs);
      logic [63:0] d;
      logic pt, po;
      d = {$random(seed), $random(seed)};
      @(posedge clock) #1;
      word = {$random(seed), $random(seed)};
      {readWrite, transferCycle, outerWordRequest, innerWordRequest} = {rw, tc, ow, iw};
      {element_source_select, io_sub_write_select, buffer_read_select, io_sub_read_select} = {es, ios, brs, irs};
      element_write_data_in = d;
      io_sub_write_data_in = d;
      cycle_initiate = 1;
      // element bytes enter inverted, io bytes as they are
      for (int s = 0; s < 8; s++)
         if (es && ((ow && mds_pkg::OUTER_SLICES[s]) || (iw && mds_pkg::INNER_SLICES[s])))
            held[8*s +: 8] = ~d[8*s +: 8];
         else if (ios) held[8*s +: 8] = d[8*s +: 8];
      pt = 0;
      po = 0;
      for (int k = 0; k < 16; k++) begin
         @(posedge clock) #1;
         cycle_initiate = 0;
         if (k == 6) begin
            element_write_data_in = ~d;
            io_sub_write_data_in = ~d;
         end
         if (k == 7 && !rw) rdExp = word;
         if (k == 5) check({outer_word_enable_latched, inner_word_enable_latched}, {ow, iw});
         if (k == 6) check({buffer_read_select_latched, ioReadSelectLatched}, {brs & !rw, irs & !rw});
         if (k == 6 || k == 8) check({transfer_enable_gate, output_enable_gate}, k == 6 ? {tc, 1'b0} : {1'b0, !rw});
         if (k == 7) check({memoryWriteValid, elementReadValid}, {rw & !tc, !rw});
         if (memoryWriteValid === 1'b1) check(memory_write_data_out, held);
         if (elementReadValid === 1'b1) check(element_read_data_out, rdExp);
         if (pt && transfer_enable_gate === 1'b1) check(buffer_io_out_data, held);
         if (po && output_enable_gate === 1'b1) check(buffer_io_out_data, rdExp);
         pt = transfer_enable_gate === 1'b1;
         po = output_enable_gate === 1'b1;
      end
   endtask : run
   initial begin
      repeat (10) @(posedge clock);
      #1 rst_n = 1;
      for (int i = 1; i < 4; i++) run(1, 0, i[1], i[0], 1, 0, 0, 0); // inner, outer, both
      run(1, 0, 0, 0, 0, 1, 0, 0); // io write of all bytes with no word requests
      run(1, 1, 1, 0, 1, 0, 0, 0); // transfer of the outer word
      run(0, 0, 0, 0, 0, 0, 0, 0); // read to the element
      run(0, 0, 0, 0, 0, 0, 1, 0); // read to the buffer
      run(0, 0, 0, 0, 0, 0, 0, 1); // read to the io side
      repeat (3) begin
         r = $random(seed);
         run(1, r[2], r[0], r[1], 1, 0, 0, 0);
      end
      wrap_up();
   end
endmodule : mds_switch_tb
